// >>> src/evs_pkg.sv
// Shared constants for exception vectoring and stack framing
package evs_pkg;

    // Program-memory vector area
    localparam logic [23:0] RESET_VECTOR     = 24'h000000; // First fetch
    localparam logic [23:0] RESET_JUMP_ARG   = 24'h000002; // Jump target word
    localparam logic [23:0] VEC_AREA_END     = 24'h000200; // Exclusive bound
    localparam logic [23:0] VEC_BASE         = 24'h000004; // Primary table
    localparam logic [23:0] VEC_STRIDE       = 24'h000002; // Address units per entry

    // Source counts and vector numbering
    localparam int          NUM_TRAPS        = 6;
    localparam int          NUM_SRC          = 246;
    localparam logic [7:0]  FIRST_IRQ_VECTOR = 8'h08;
    localparam logic [3:0]  TRAP_LEVEL       = 4'h8;   // Above all users
    localparam int          PRIO_W           = 3;      // Seven user levels

    // Boot segment and alternate table placement
    localparam int          PAGE_SHIFT       = 11;     // Log2 of page span, addr units
    localparam logic [12:0] MIN_BOOT_PAGES   = 13'h0002;

    // Stack pointer
    localparam logic [15:0] SP_RESET         = 16'h1000;
    localparam logic [15:0] SP_STEP          = 16'h0002;

    // Register port map (word addresses)
    localparam int          ADDR_W           = 4;
    localparam logic [3:0]  REG_INTCTL2      = 4'h0;
    localparam logic [3:0]  REG_SP           = 4'h1;
    localparam logic [3:0]  REG_FP           = 4'h2;
    localparam logic [3:0]  REG_SRC_SEL      = 4'h3;
    localparam logic [3:0]  REG_SRC_CFG      = 4'h4;
    localparam logic [3:0]  REG_STATUS       = 4'h5;

    // Field positions
    localparam int          BIT_ALT_EN       = 8;  // interrupt_control_two
    localparam int          BIT_FP_ACT       = 1;  // interrupt_control_two
    localparam int          BIT_SRC_EN       = 3;  // Source config word
    localparam int          BIT_ST_BUSY      = 8;  // Status word
    localparam int          BIT_ST_IRQ       = 9;
    localparam int          BIT_ST_ALT       = 10;

    // Framing sequencer
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PUSH_LO = 3'b001,
        ST_PUSH_HI = 3'b010,
        ST_FETCH   = 3'b011,
        ST_VWAIT   = 3'b100,
        ST_POP_HI  = 3'b101,
        ST_POP_LO  = 3'b110,
        ST_POP_END = 3'b111
    } evs_state_t;

endpackage

// >>> src/evs_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] Vectors live below program address 0x200
// [RULE2] Reset fetch at zero, jump target next
// [RULE3] Primary table starts at word 0x4
// [RULE4] Six traps, 246 sources, one vector each
// [RULE5] Each vector entry is a 24-bit address
// [RULE6] Lower vector number wins natural priority
// [RULE7] Seven user levels, ties by vector order
// [RULE8] Many request lines merge to one request
// [RULE9] Fixed entry and return cycle counts
// [RULE10] Alternate table needs segment, fuse, enable bit
// [RULE11] Alternate table serves every exception when on
// [RULE12] Alternate table at last boot page start
// [RULE13] Boot segment two pages before enabling
// [RULE14] Tables share boot segment code protection
// [RULE15] Stack pointer auto-updated yet software accessible
// [RULE16] Stack pointer bit zero always zero
// [RULE17] Reset loads stack pointer with 0x1000
// [RULE18] Stack grows up, post-increment, pre-decrement
// [RULE19] PC low word first, high word second
// [RULE20] Exception push adds status low byte
// [RULE21] Stack and frame pointers stay 16-bit
// [RULE22] Request only above core's current level
module evs_core (
    input  wire logic                        clock,
    input  wire logic                        rst,
    // Register port
    input  wire logic [evs_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [15:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [15:0]                 reg_rdata,
    // Configuration pins (asynchronous, synchronised here)
    input  wire logic                        alt_table_fuse,
    input  wire logic                        boot_segment_defined,
    input  wire logic [12:0]                 boot_segment_limit,
    input  wire logic                        boot_code_protect,
    // Peripheral and trap requests
    input  wire logic [evs_pkg::NUM_SRC-1:0] irq_lines,
    input  wire logic [evs_pkg::NUM_TRAPS-1:0] trap_lines,
    // Processor core side
    input  wire logic [2:0]                  cpu_priority,
    input  wire logic                        core_ack,
    input  wire logic                        call_push,
    input  wire logic                        ret_pop,
    input  wire logic [22:0]                 core_pc,
    input  wire logic [7:0]                  cpu_status_low_byte,
    output logic                             core_irq,
    output logic      [7:0]                  vector_num,
    output logic                             boot_start,
    output logic      [23:0]                 handler_addr,
    output logic                             entry_done,
    output logic      [22:0]                 ret_pc,
    output logic      [7:0]                  ret_status,
    output logic                             ret_done,
    output logic                             frame_pointer_active,
    // Data-space stack port
    output logic                             mem_wr,
    output logic                             mem_rd,
    output logic      [15:0]                 mem_addr,
    output logic      [15:0]                 mem_wdata,
    input  wire logic [15:0]                 mem_rdata,
    // Program-space vector fetch port
    output logic                             fetch_rd,
    output logic      [23:0]                 fetch_addr,
    output logic                             fetch_protect,
    input  wire logic [23:0]                 fetch_data
);
    import evs_pkg::*;

    // Whole block state in one record
    typedef struct packed {
        evs_state_t                  st;        // Sequencer state
        logic [15:0]                 sp;        // stack_pointer_reg
        logic [15:0]                 fp;        // frame_pointer_reg
        logic                        fp_act;    // Frame pointer option
        logic                        alt_en;    // alt_table_enable
        logic [7:0]                  src_sel;   // Source config index
        logic [NUM_SRC-1:0]          src_en;    // Per-source enables
        logic [NUM_SRC-1:0][PRIO_W-1:0] src_prio; // Per-source levels
        logic [1:0]                  fuse_s;    // Synchroniser pairs
        logic [1:0]                  bsd_s;
        logic [1:0]                  prot_s;
        logic [12:0]                 lim_s1;
        logic [12:0]                 lim_s2;
        logic                        core_irq;  // Merged request
        logic [7:0]                  vec_num;   // Winning vector
        logic [3:0]                  irq_lvl;   // Winning level
        logic                        exc;       // Frame is an exception
        logic                        alt_used;  // Table chosen at entry
        logic [15:0]                 hold_hi;   // Upper frame word
        logic                        mem_wr;
        logic                        mem_rd;
        logic [15:0]                 mem_addr;
        logic [15:0]                 mem_wdata;
        logic                        fetch_rd;
        logic [23:0]                 fetch_addr;
        logic                        fetch_prot;
        logic [23:0]                 handler;
        logic                        entry_done;
        logic [15:0]                 ret_hi;    // First popped word
        logic [22:0]                 ret_pc;
        logic [7:0]                  ret_status;
        logic                        ret_done;
        logic [15:0]                 rdata;
        logic                        boot_start;
    } evs_regs_t;

    evs_regs_t    r_reg;       // Registered state
    evs_regs_t    r_next;      // Next state
    logic         ent_go;      // Exception entry accepted
    logic         call_go;     // Call push accepted
    logic         ret_go;      // Return accepted
    logic         alt_ok;      // Alternate table usable now
    logic [10:0]  pick;        // Best user source {level, index}
    logic         trap_hit;    // Any trap pending
    logic [7:0]   trap_vec;    // Lowest pending trap
    logic         want;        // Request worth raising
    logic [7:0]   win_vec;     // Candidate vector
    logic [3:0]   win_lvl;     // Candidate level

    // Highest user level wins; strict compare keeps lowest index on ties
    function automatic logic [10:0] evs_pick(
        input logic [NUM_SRC-1:0]             req,
        input logic [NUM_SRC-1:0]             en,
        input logic [NUM_SRC-1:0][PRIO_W-1:0] pr
    );
        logic [2:0] bp;
        logic [7:0] bi;
        bp = '0;
        bi = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && en[i] && (pr[i] > bp)) begin // RULE7
                bp = pr[i];
                bi = 8'(i);
            end
        end
        return {bp, bi};
    endfunction

    // Entry address of a vector, primary or relocated to the boot page
    function automatic logic [23:0] evs_vec_addr(
        input logic [7:0]  v,
        input logic        alt,
        input logic [12:0] lim
    );
        logic [23:0] prim;
        logic [23:0] base;
        prim = VEC_BASE + (VEC_STRIDE * {16'h0, v}); // RULE3
        base = alt ? {13'(lim - 13'h1), 11'h0} : 24'h0; // RULE12
        return 24'(prim + base);
    endfunction

    // Next-state logic
    always_comb begin
        r_next  = r_reg;
        ent_go  = 1'b0;
        call_go = 1'b0;
        ret_go  = 1'b0;

        // Two-flop capture of the static configuration pins
        r_next.fuse_s = {r_reg.fuse_s[0], alt_table_fuse};
        r_next.bsd_s  = {r_reg.bsd_s[0], boot_segment_defined};
        r_next.prot_s = {r_reg.prot_s[0], boot_code_protect};
        r_next.lim_s1 = boot_segment_limit;
        r_next.lim_s2 = r_reg.lim_s1;

        // Pulses default low
        r_next.mem_wr     = 1'b0;
        r_next.mem_rd     = 1'b0;
        r_next.fetch_rd   = 1'b0;
        r_next.entry_done = 1'b0;
        r_next.ret_done   = 1'b0;
        r_next.boot_start = 1'b0;
        r_next.rdata      = 16'h0000;

        // Short segments are refused so the table never lands on page 0
        alt_ok = r_reg.fuse_s[1] && r_reg.bsd_s[1] && r_reg.alt_en
                 && (r_reg.lim_s2 >= MIN_BOOT_PAGES); // RULE10 RULE13

        // Trap search: lowest number wins
        trap_hit = 1'b0;
        trap_vec = 8'h00;
        for (int i = NUM_TRAPS - 1; i >= 0; i--) begin
            if (trap_lines[i]) begin // RULE6
                trap_hit = 1'b1;
                trap_vec = 8'(i);
            end
        end
        pick = evs_pick(irq_lines, r_reg.src_en, r_reg.src_prio);

        // Traps are non-maskable; users must beat the core level
        if (trap_hit) begin // RULE4
            want    = 1'b1;
            win_vec = trap_vec;
            win_lvl = TRAP_LEVEL;
        end else begin
            want    = (pick[10:8] > cpu_priority); // RULE22
            win_vec = 8'(FIRST_IRQ_VECTOR + pick[7:0]);
            win_lvl = {1'b0, pick[10:8]};
        end

        // Register reads, answered in the next cycle
        if (reg_rd) begin
            unique case (reg_addr)
                REG_INTCTL2: begin
                    r_next.rdata[BIT_ALT_EN] = r_reg.alt_en;
                    r_next.rdata[BIT_FP_ACT] = r_reg.fp_act;
                end
                REG_SP:      r_next.rdata = r_reg.sp; // RULE15
                REG_FP:      r_next.rdata = r_reg.fp;
                REG_SRC_SEL: r_next.rdata = {8'h00, r_reg.src_sel};
                REG_SRC_CFG: begin
                    if (r_reg.src_sel < 8'(NUM_SRC)) begin
                        r_next.rdata[BIT_SRC_EN] =
                            r_reg.src_en[r_reg.src_sel];
                        r_next.rdata[PRIO_W-1:0] =
                            r_reg.src_prio[r_reg.src_sel];
                    end
                end
                REG_STATUS: begin
                    r_next.rdata[7:0]         = r_reg.vec_num;
                    r_next.rdata[BIT_ST_BUSY] = (r_reg.st != ST_IDLE);
                    r_next.rdata[BIT_ST_IRQ]  = r_reg.core_irq;
                    r_next.rdata[BIT_ST_ALT]  = alt_ok;
                end
                default: r_next.rdata = 16'h0000; // Unmapped reads zero
            endcase
        end

        // Register writes; the sequencer below overrides the pointer
        if (reg_wr) begin
            unique case (reg_addr)
                REG_INTCTL2: begin
                    r_next.alt_en = reg_wdata[BIT_ALT_EN];
                    r_next.fp_act = reg_wdata[BIT_FP_ACT];
                end
                REG_SP:      r_next.sp = {reg_wdata[15:1], 1'b0}; // RULE16
                REG_FP:      r_next.fp = reg_wdata; // RULE21
                REG_SRC_SEL: r_next.src_sel = reg_wdata[7:0];
                REG_SRC_CFG: begin
                    if (r_reg.src_sel < 8'(NUM_SRC)) begin
                        r_next.src_en[r_reg.src_sel] =
                            reg_wdata[BIT_SRC_EN];
                        r_next.src_prio[r_reg.src_sel] =
                            reg_wdata[PRIO_W-1:0];
                    end
                end
                default: ; // Writes elsewhere are dropped
            endcase
        end

        // Framing sequencer; hardware pointer updates win over software
        unique case (r_reg.st)
            ST_IDLE: begin
                if (core_ack && r_reg.core_irq) begin
                    ent_go          = 1'b1;
                    r_next.exc      = 1'b1;
                    r_next.alt_used = alt_ok; // RULE11
                    r_next.hold_hi  = {cpu_status_low_byte, 1'b0,
                                       core_pc[22:16]}; // RULE20
                end else if (call_push) begin
                    call_go         = 1'b1;
                    r_next.exc      = 1'b0;
                    r_next.hold_hi  = {9'h000, core_pc[22:16]}; // RULE19
                end else if (ret_pop) begin
                    ret_go          = 1'b1;
                    r_next.st       = ST_POP_HI;
                    r_next.mem_rd   = 1'b1;
                    r_next.mem_addr = 16'(r_reg.sp - SP_STEP); // RULE18
                    r_next.sp       = 16'(r_reg.sp - SP_STEP);
                end
                if (ent_go || call_go) begin
                    // Write then increment; wraps inside 16 bits
                    r_next.st        = ST_PUSH_LO;
                    r_next.mem_wr    = 1'b1;
                    r_next.mem_addr  = r_reg.sp;
                    r_next.mem_wdata = core_pc[15:0]; // RULE19
                    r_next.sp        = 16'(r_reg.sp + SP_STEP); // RULE18
                end
            end
            ST_PUSH_LO: begin
                r_next.st        = ST_PUSH_HI;
                r_next.mem_wr    = 1'b1;
                r_next.mem_addr  = r_reg.sp;
                r_next.mem_wdata = r_reg.hold_hi;
                r_next.sp        = 16'(r_reg.sp + SP_STEP); // RULE15
            end
            ST_PUSH_HI: begin
                if (r_reg.exc) begin
                    r_next.st         = ST_FETCH;
                    r_next.fetch_rd   = 1'b1;
                    r_next.fetch_addr = evs_vec_addr(r_reg.vec_num,
                        r_reg.alt_used, r_reg.lim_s2); // RULE1
                    r_next.fetch_prot = r_reg.prot_s[1]; // RULE14
                end else begin
                    r_next.st = ST_IDLE;
                end
            end
            ST_FETCH: r_next.st = ST_VWAIT; // Fetch data due next cycle
            ST_VWAIT: begin
                r_next.st         = ST_IDLE;
                r_next.handler    = fetch_data; // RULE5
                r_next.entry_done = 1'b1; // RULE9
            end
            ST_POP_HI: begin
                r_next.st       = ST_POP_LO;
                r_next.mem_rd   = 1'b1;
                r_next.mem_addr = 16'(r_reg.sp - SP_STEP);
                r_next.sp       = 16'(r_reg.sp - SP_STEP);
            end
            ST_POP_LO: begin
                r_next.st     = ST_POP_END;
                r_next.ret_hi = mem_rdata; // Upper frame word
            end
            ST_POP_END: begin
                r_next.st         = ST_IDLE;
                r_next.ret_pc     = {r_reg.ret_hi[6:0], mem_rdata};
                r_next.ret_status = r_reg.ret_hi[15:8];
                r_next.ret_done   = 1'b1; // RULE9
            end
        endcase

        // Merged request: held low while a frame is in flight, vector and level frozen
        if (r_reg.st == ST_IDLE && !ent_go && !call_go && !ret_go) begin
            r_next.core_irq = want; // RULE8
            r_next.vec_num  = win_vec;
            r_next.irq_lvl  = win_lvl;
        end else begin
            r_next.core_irq = 1'b0;
        end
    end

    // State register; reset only loads constants
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_reg            <= '0;
            r_reg.sp         <= SP_RESET; // RULE17
            r_reg.handler    <= RESET_VECTOR; // RULE2
            r_reg.boot_start <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state record
    assign reg_rdata            = r_reg.rdata;
    assign core_irq             = r_reg.core_irq;
    assign vector_num           = r_reg.vec_num;
    assign boot_start           = r_reg.boot_start;
    assign handler_addr         = r_reg.handler;
    assign entry_done           = r_reg.entry_done;
    assign ret_pc               = r_reg.ret_pc;
    assign ret_status           = r_reg.ret_status;
    assign ret_done             = r_reg.ret_done;
    assign frame_pointer_active = r_reg.fp_act;
    assign mem_wr               = r_reg.mem_wr;
    assign mem_rd               = r_reg.mem_rd;
    assign mem_addr             = r_reg.mem_addr;
    assign mem_wdata            = r_reg.mem_wdata;
    assign fetch_rd             = r_reg.fetch_rd;
    assign fetch_addr           = r_reg.fetch_addr;
    assign fetch_protect        = r_reg.fetch_prot;

    // Checks on the framing and arbitration behaviour
    property p_sp_aligned;
        @(posedge clock) disable iff (rst) r_reg.sp[0] == 1'b0;
    endproperty
    a_sp_aligned: assert property (p_sp_aligned) // RULE16
        else $error("stack pointer misaligned");

    property p_entry_time;
        @(posedge clock) disable iff (rst)
        ent_go |=> !entry_done [*4] ##1 entry_done;
    endproperty
    a_entry_time: assert property (p_entry_time) // RULE9
        else $error("entry latency not five cycles");

    property p_return_time;
        @(posedge clock) disable iff (rst) ret_go |-> ##4 ret_done;
    endproperty
    a_return_time: assert property (p_return_time) // RULE9
        else $error("return latency not four cycles");

    property p_push_post_inc;
        @(posedge clock) disable iff (rst)
        mem_wr |-> r_reg.sp == 16'(mem_addr + 16'h0002);
    endproperty
    a_push_post_inc: assert property (p_push_post_inc) // RULE18
        else $error("push did not post-increment");

    property p_pop_pre_dec;
        @(posedge clock) disable iff (rst) mem_rd |-> r_reg.sp == mem_addr;
    endproperty
    a_pop_pre_dec: assert property (p_pop_pre_dec) // RULE18
        else $error("pop did not pre-decrement");

    property p_exc_frame;
        @(posedge clock) disable iff (rst)
        ent_go |=> mem_wdata == $past(core_pc[15:0])
            ##1 mem_wdata == {$past(cpu_status_low_byte, 2), 1'b0,
                              $past(core_pc[22:16], 2)};
    endproperty
    a_exc_frame: assert property (p_exc_frame) // RULE20
        else $error("exception frame words wrong");

    property p_call_zero_ext;
        @(posedge clock) disable iff (rst)
        call_go |=> ##1 mem_wr && mem_wdata[15:7] == 9'h000;
    endproperty
    a_call_zero_ext: assert property (p_call_zero_ext) // RULE19
        else $error("call high word not zero-extended");

    property p_level_gate;
        @(posedge clock) disable iff (rst)
        core_irq |-> (r_reg.irq_lvl == TRAP_LEVEL)
            || (r_reg.irq_lvl[2:0] > $past(cpu_priority));
    endproperty
    a_level_gate: assert property (p_level_gate) // RULE22
        else $error("request at or below core level");

    property p_vec_area;
        @(posedge clock) disable iff (rst)
        (fetch_rd && !r_reg.alt_used) |-> fetch_addr < VEC_AREA_END;
    endproperty
    a_vec_area: assert property (p_vec_area) // RULE1
        else $error("primary fetch outside vector area");

    c_entry:   cover property (@(posedge clock) disable iff (rst)
        entry_done);
    c_return:  cover property (@(posedge clock) disable iff (rst)
        ret_done);
    c_alt:     cover property (@(posedge clock) disable iff (rst)
        fetch_rd && r_reg.alt_used);
    c_trap:    cover property (@(posedge clock) disable iff (rst)
        core_irq && r_reg.irq_lvl == TRAP_LEVEL);

endmodule // evs_core

// >>> tb/evs_core_model.sv
`timescale 1ns/1ns
// Core-side memories: data stack words and program vector words
module evs_core_model (
    input  wire logic        clock,
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    input  wire logic        fetch_rd,
    input  wire logic [23:0] fetch_addr,
    output logic      [23:0] fetch_data
);
    logic [15:0] ram [logic [15:0]]; // Sparse stack store
    initial begin
        mem_rdata = 16'h0000;
        fetch_data = 24'h000000;
    end
    // Answer one cycle after a strobe; otherwise scramble, never hold
    always @(posedge clock) begin
        if (mem_wr) ram[mem_addr] = mem_wdata;
        mem_rdata <= mem_rd ? ram[mem_addr] : ~mem_rdata;
        // Vector word is its own address plus a marker, 24 bits wide
        fetch_data <= fetch_rd ? fetch_addr + 24'h010000 : ~fetch_data;
    end
endmodule // evs_core_model

// >>> tb/tb_top.sv
`timescale 1ns/1ns
// Bench: driver notes expectations, monitor compares on results
module tb_top;
    import evs_pkg::*;
    logic                 clock, rst, reg_wr, reg_rd, core_ack, rd_d;
    logic                 call_push, ret_pop, alt_table_fuse, core_irq;
    logic                 boot_segment_defined, boot_code_protect, mem_wr;
    logic                 boot_start, entry_done, ret_done, mem_rd;
    logic                 frame_pointer_active, fetch_rd, fetch_protect;
    logic [ADDR_W-1:0]    reg_addr;
    logic [15:0]          reg_wdata, reg_rdata, mem_rdata, mem_addr, mem_wdata;
    logic [NUM_SRC-1:0]   irq_lines;
    logic [NUM_TRAPS-1:0] trap_lines;
    logic [2:0]           cpu_priority;
    logic [22:0]          core_pc, ret_pc;
    logic [7:0]           cpu_status_low_byte, vector_num, ret_status;
    logic [12:0]          boot_segment_limit;
    logic [23:0]          handler_addr, fetch_addr, fetch_data;
    logic [31:0]          seed, r, exp_q[$];
    int                   n_fail, comparisons;
    evs_core uut (.*);
    evs_core_model core (.clock, .mem_wr, .mem_rd, .mem_addr, .mem_wdata,
        .mem_rdata, .fetch_rd, .fetch_addr, .fetch_data);
    task automatic complete_run;
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Xorshift keeps the pushed PC and status varied but repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        if (w) reg_wr <= 1'b1;
        else reg_rd <= 1'b1;
        if (!w) exp_q.push_back({16'h0000, d});
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    // Wait for the merged request, bounded
    task automatic take(input logic [7:0] v, input logic [23:0] off);
        // Two edges at least, so a new winner has reached vector_num
        for (int i = 0; i < 20 && (i < 2 || core_irq !== 1'b1); i++)
            @(negedge clock);
        if (core_irq !== 1'b1) n_fail++;
        if (core_irq !== 1'b1) complete_run();
        chk(vector_num, v);
        r = rnd();
        exp_q.push_back(VEC_BASE + VEC_STRIDE * v + off + 24'h010000);
        @(posedge clock);
        {cpu_status_low_byte, core_pc} <= r[30:0];
        core_ack <= 1'b1;
        @(posedge clock);
        core_ack <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock) chk(entry_done, 1'b0);
        @(negedge clock) chk(entry_done, 1'b1);
    endtask
    task automatic pop(input logic [31:0] e);
        @(posedge clock);
        ret_pop <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        ret_pop <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock) chk(ret_done, 1'b0);
        @(negedge clock) chk(ret_done, 1'b1);
    endtask
    // Read data is valid only in the cycle after the read strobe
    always @(posedge clock) rd_d <= reg_rd;
    // Protection pin is tied high, so every vector fetch is protected
    always @(negedge clock)
        if (fetch_rd === 1'b1) chk(fetch_protect, 1'b1);
    always @(negedge clock) begin
        if (rd_d === 1'b1 || entry_done === 1'b1 || ret_done === 1'b1) begin
            if (exp_q.size() == 0) chk(32'hffff_ffff, 32'h0);
            else chk(rd_d ? reg_rdata : entry_done ? handler_addr
                : {ret_pc, ret_status}, exp_q.pop_front());
        end
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {rst, rd_d, seed, n_fail, comparisons} = {1'b1, 1'b0, 32'hae6e, 64'h0};
        {reg_wr, reg_rd, core_ack, call_push, ret_pop, reg_addr} = '0;
        {reg_wdata, irq_lines, trap_lines, core_pc, cpu_status_low_byte} = '0;
        {alt_table_fuse, boot_segment_defined, boot_code_protect} = 3'h7;
        cpu_priority = '0;
        boot_segment_limit = 13'h0003;
        repeat (5) @(posedge clock);
        @(negedge clock) chk({boot_start, handler_addr}, 32'h1000000);
        @(posedge clock) rst <= 1'b0;
        bus(0, REG_SP, 16'h1000);
        bus(1, REG_SP, 16'h2001);
        bus(0, REG_SP, 16'h2000);
        for (int i = 1; i < 4; i++) begin
            bus(1, REG_SRC_SEL, 16'(i));
            bus(1, REG_SRC_CFG, i == 2 ? 16'h000c : 16'h000d);
        end
        irq_lines[3:1] <= 3'h7;
        cpu_priority <= 3'h5;
        repeat (4) @(negedge clock);
        chk(core_irq, 1'b0);
        @(posedge clock) cpu_priority <= 3'h4;
        take(8'h09, 24'h0);
        pop({1'b0, r[22:0], r[30:23]});
        bus(0, REG_SP, 16'h2000);
        @(posedge clock) trap_lines <= 6'h14;
        take(8'h02, 24'h0);
        pop({1'b0, r[22:0], r[30:23]});
        r = rnd();
        @(posedge clock) {trap_lines, core_pc, call_push}
            <= {6'h0, r[22:0], 1'b1};
        @(posedge clock) call_push <= 1'b0;
        @(posedge clock); // Call frame still being written
        pop({1'b0, r[22:0], 8'h00});
        bus(1, REG_INTCTL2, 16'h0102);
        bus(0, REG_INTCTL2, 16'h0102);
        chk(frame_pointer_active, 1'b1);
        @(posedge clock) trap_lines <= 6'h01;
        take(8'h00, 24'h000002 << PAGE_SHIFT);
        complete_run();
    end
endmodule // tb_top
